// >>> verilog/gpio_port_pkg.sv
// Constants, types and decode helpers shared by the general-purpose port
package gpio_port_pkg;

    // ------------------------------------------------------------
    // Geometry and register selects
    // ------------------------------------------------------------
    localparam int          PORT_WIDTH     = 8;
    localparam int          BIT_IDX_WIDTH  = 3;
    localparam logic        ADDR_DATA      = 1'h0;
    localparam logic        ADDR_DIR       = 1'h1;

    // ------------------------------------------------------------
    // Reset and fixed read values
    // ------------------------------------------------------------
    localparam logic [7:0]  LATCH_RESET    = 8'h00;
    localparam logic [7:0]  DIR_RESET      = 8'h00;
    localparam logic [7:0]  DIR_READ_VALUE = 8'hFF;
    localparam logic [7:0]  BYTE_ZERO      = 8'h00;
    localparam logic [7:0]  BYTE_ONE       = 8'h01;

    // ------------------------------------------------------------
    // Bit-set sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_READ   = 2'b01,
        ST_MODIFY = 2'b10,
        ST_WRITE  = 2'b11
    } rmw_state_t;

    typedef struct packed {
        rmw_state_t               state;
        logic                     busy;
        logic [7:0]               latch;
        logic [7:0]               dir;
        logic [7:0]               rmw_byte;
        logic [BIT_IDX_WIDTH-1:0] bit_idx;
        logic [7:0]               rdata;
        logic                     rvalid;
    } port_state_t;

    // One-hot mask of a bit index
    function automatic logic [7:0] bit_mask(input logic [BIT_IDX_WIDTH-1:0] idx);
        bit_mask = BYTE_ONE << idx;
    endfunction

endpackage

// >>> verilog/port_readback.sv
// Per-pin selection of the byte returned by a data read
module port_readback
    import gpio_port_pkg::*;
#(
    parameter int WIDTH = PORT_WIDTH
) (
    input  wire logic [WIDTH-1:0] dir,      // 1 = output pin
    input  wire logic [WIDTH-1:0] latch,    // Data latch bits
    input  wire logic [WIDTH-1:0] pin_in,   // Live pin levels
    output logic      [WIDTH-1:0] value     // Readback byte
);

    // ------------------------------------------------------------
    // Output pins show the latch, input pins the live level
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            assign value[i] = dir[i] ? latch[i] : pin_in[i];
        end
    endgenerate

endmodule

// >>> verilog/gpio_port.sv
// Eight-pin general-purpose port with data latch, direction register and bit set
//
// Summary of operation
// - Data read returns live level of inputs
// - Data read returns latch bit of outputs
// - Byte write replaces all eight latch bits when no bit set is running
// - Output pin drives its latch bit level
// - Bit set rewrites whole latch from readback, input bits take pin level
// - Direction register write-only, reads as all ones
// - Direction bit one means output, zero input
module gpio_port
    import gpio_port_pkg::*;
(
    input  wire logic                     clk,       // 200 MHz clock
    input  wire logic                     rstn,      // Async reset, active low
    input  wire logic                     bus_addr,  // 0 data latch, 1 direction
    input  wire logic                     bus_wr,    // Byte write strobe
    input  wire logic                     bus_rd,    // Byte read strobe
    input  wire logic [7:0]               bus_wdata, // Write data
    output logic      [7:0]               bus_rdata, // Read data, registered
    output logic                          bus_rvalid,// Read data valid pulse
    input  wire logic                     bit_set_instruction_req,  // Start bit-set sequence
    input  wire logic [BIT_IDX_WIDTH-1:0] bit_set_instruction_bit,  // Bit to set
    output logic                          bit_set_instruction_busy, // Bit-set sequence running
    input  wire logic [7:0]               pin_in,    // Pin levels
    output logic      [7:0]               pin_out,   // Pin drive levels
    output logic      [7:0]               pin_oe     // Pin drive enables
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    port_state_t st;
    port_state_t next_st;
    logic [7:0]  readback;
    logic        wr_ok;
    logic        bit_set_instruction_ok;

    port_readback #(
        .WIDTH (PORT_WIDTH)
    ) u_readback (
        .dir    (st.dir),
        .latch  (st.latch),
        .pin_in (pin_in),
        .value  (readback)
    );

    // Writes are refused while a bit set owns the latch, so its rewrite
    // cannot silently undo a byte write issued in between.
    assign wr_ok   = bus_wr && !st.busy;
    assign bit_set_instruction_ok = bit_set_instruction_req && (st.state == ST_IDLE);

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_st        = st;
        next_st.rvalid = 1'b0;

        if (bus_rd) begin
            next_st.rvalid = 1'b1;
            if (bus_addr == ADDR_DIR) begin
                next_st.rdata = DIR_READ_VALUE;
            end else begin
                next_st.rdata = readback;
            end
        end

        if (wr_ok) begin
            if (bus_addr == ADDR_DIR) begin
                next_st.dir = bus_wdata;
            end else begin
                next_st.latch = bus_wdata;
            end
        end

        unique case (st.state)
            ST_IDLE: begin
                if (bit_set_instruction_ok) begin
                    next_st.state   = ST_READ;
                    next_st.busy    = 1'b1;
                    next_st.bit_idx = bit_set_instruction_bit;
                end
            end
            ST_READ: begin
                // Inputs come back as pin levels, which is the known hazard
                next_st.rmw_byte = readback;
                next_st.state    = ST_MODIFY;
            end
            ST_MODIFY: begin
                next_st.rmw_byte = st.rmw_byte | bit_mask(st.bit_idx);
                next_st.state    = ST_WRITE;
            end
            ST_WRITE: begin
                next_st.latch = st.rmw_byte;
                next_st.state = ST_IDLE;
                next_st.busy  = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st.state    <= ST_IDLE;
            st.busy     <= 1'b0;
            st.latch    <= LATCH_RESET;
            st.dir      <= DIR_RESET;
            st.rmw_byte <= BYTE_ZERO;
            st.bit_idx  <= '0;
            st.rdata    <= BYTE_ZERO;
            st.rvalid   <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign pin_out    = st.latch;
    assign pin_oe     = st.dir;
    assign bus_rdata  = st.rdata;
    assign bus_rvalid = st.rvalid;
    assign bit_set_instruction_busy  = st.busy;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence s_bit_set_instruction_start;
        bit_set_instruction_req && !bit_set_instruction_busy;
    endsequence

    sequence s_bit_set_instruction_run;
        bit_set_instruction_busy [*3];
    endsequence

    property p_read_inputs;
        bus_rd && bus_addr == ADDR_DATA |=>
            (bus_rdata & ~$past(pin_oe)) == ($past(pin_in) & ~$past(pin_oe));
    endproperty
    a_read_inputs: assert property (p_read_inputs)
        else $error("input pin readback wrong");

    property p_read_outputs;
        bus_rd && bus_addr == ADDR_DATA |=>
            (bus_rdata & $past(pin_oe)) == ($past(pin_out) & $past(pin_oe));
    endproperty
    a_read_outputs: assert property (p_read_outputs)
        else $error("output pin readback wrong");

    property p_byte_write;
        bus_wr && !bit_set_instruction_busy && bus_addr == ADDR_DATA && !bit_set_instruction_req |=>
            pin_out == $past(bus_wdata);
    endproperty
    a_byte_write: assert property (p_byte_write)
        else $error("byte write did not replace latch");

    property p_latch_hold;
        !$past(wr_ok && bus_addr == ADDR_DATA) && $past(st.state) != ST_WRITE
            |-> $stable(pin_out);
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("pin drive changed without a write");

    property p_bit_set_instruction_result;
        s_bit_set_instruction_start |-> ##4
            pin_out == ($past(readback, 3) | bit_mask($past(bit_set_instruction_bit, 4)));
    endproperty
    a_bit_set_instruction_result: assert property (p_bit_set_instruction_result)
        else $error("bit set result wrong");

    property p_bit_set_instruction_timing;
        s_bit_set_instruction_start |=> s_bit_set_instruction_run ##1 !bit_set_instruction_busy;
    endproperty
    a_bit_set_instruction_timing: assert property (p_bit_set_instruction_timing)
        else $error("bit set sequence length wrong");

    property p_dir_read;
        bus_rd && bus_addr == ADDR_DIR |=> bus_rvalid && bus_rdata == DIR_READ_VALUE;
    endproperty
    a_dir_read: assert property (p_dir_read)
        else $error("direction read not all ones");

    property p_dir_write;
        bus_wr && !bit_set_instruction_busy && bus_addr == ADDR_DIR |=> pin_oe == $past(bus_wdata);
    endproperty
    a_dir_write: assert property (p_dir_write)
        else $error("direction write not applied");

    property p_read_answer;
        bus_rd |=> bus_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read not answered one cycle later");

    property p_read_quiet;
        !bus_rd |=> !bus_rvalid && $stable(bus_rdata);
    endproperty
    a_read_quiet: assert property (p_read_quiet)
        else $error("read data moved without a read");

    property p_dir_hold;
        !(wr_ok && bus_addr == ADDR_DIR) |=> $stable(pin_oe);
    endproperty
    a_dir_hold: assert property (p_dir_hold)
        else $error("pin direction changed without a write");

    // Refused writes must not reach the latch ahead of the rewrite step
    property p_write_refused;
        bus_wr && bit_set_instruction_busy && st.state != ST_WRITE |=> $stable(pin_out);
    endproperty
    a_write_refused: assert property (p_write_refused)
        else $error("write during bit set reached the latch");

endmodule

// >>> verification/pin_circuit_model.sv
// Behavioural model of the outside circuitry wired to the eight port pins
module pin_circuit_model (
    input  wire logic [7:0] pin_out,   // Port drive levels
    input  wire logic [7:0] pin_oe,    // Port drive enables
    input  wire logic [7:0] ext_level, // Levels that outside parts force
    output logic      [7:0] pin_in     // Resolved pin levels
);
    timeunit 1ns;
    timeprecision 1ps;

    // Driven pins follow the port, undriven pins follow the outside part
    assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule

// >>> verification/testbench.sv
// Self-checking bench for the general-purpose port
module testbench
    import gpio_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk = 1'b0, rstn = 1'b0, bus_addr = 1'b0, bus_wr = 1'b0;
    logic       bus_rd = 1'b0, bit_set_instruction_req = 1'b0, bus_rvalid, bit_set_instruction_busy;
    logic [2:0] bit_set_instruction_bit = 3'h0;
    logic [7:0] bus_wdata = 8'h00, ext = 8'h00, m_latch = 8'h00, m_dir = 8'h00;
    logic [7:0] bus_rdata, pin_in, pin_out, pin_oe;
    logic [7:0] exp_q[$];
    int         fails = 0, checked = 0;

    always #2.5 clk = ~clk;

    gpio_port i_dut (
        .clk(clk), .rstn(rstn), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
        .bit_set_instruction_req(bit_set_instruction_req), .bit_set_instruction_bit(bit_set_instruction_bit), .bit_set_instruction_busy(bit_set_instruction_busy),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));

    pin_circuit_model i_pins (
        .pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in));

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("Counts: %0d compared, %0d mismatched", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Oldest note matches the oldest read answer
    always @(negedge clk) begin
        if (bus_rvalid === 1'b1) begin
            if (exp_q.size() == 0)
                check(8'(exp_q.size()), 8'h01);
            else
                check(bus_rdata, exp_q.pop_front());
        end
    end

    // ------------------------------------------------------------
    // Bus drivers, inputs change on the falling edge
    // ------------------------------------------------------------
    task automatic wr(input logic a, input logic [7:0] d);
        @(negedge clk);
        bus_addr = a;
        bus_wdata = d;
        bus_wr = 1'b1;
        @(negedge clk);
        bus_wr = 1'b0;
        if (a == ADDR_DATA) m_latch = d;
        else m_dir = d;
        check(pin_out, m_latch);
        check(pin_oe, m_dir);
    endtask

    task automatic rd(input logic a);
        @(negedge clk);
        bus_addr = a;
        bus_rd = 1'b1;
        exp_q.push_back(a == ADDR_DIR ? 8'hFF : (ext & ~m_dir) | (m_latch & m_dir));
        @(negedge clk);
        bus_rd = 1'b0;
    endtask

    task automatic bit_set_instruction(input logic [2:0] b);
        int         n;
        logic [7:0] e;
        e = (ext & ~m_dir) | (m_latch & m_dir) | (8'h01 << b);
        @(negedge clk);
        bit_set_instruction_req = 1'b1;
        bit_set_instruction_bit = b;
        @(negedge clk);
        bit_set_instruction_req = 1'b0;
        n = 0;
        while (bit_set_instruction_busy === 1'b1 && n < 8) begin
            n++;
            @(negedge clk);
        end
        if (n == 8) begin
            fails++;
            stop_test();
        end
        check(8'(n), 8'h03);
        check(pin_out, e);
        m_latch = e;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hE97C));
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        @(negedge clk);
        check(pin_out, LATCH_RESET);
        check(pin_oe, DIR_RESET);
        $display("Test reset done");
        // Two inputs low and high, six outputs low
        ext = 8'h40;
        wr(ADDR_DIR, 8'h3F);
        rd(ADDR_DIR);
        wr(ADDR_DATA, 8'h80);
        rd(ADDR_DATA);
        bit_set_instruction(3'h0);
        check(pin_out, 8'h41);
        // Whole-byte rewrite from a kept copy restores the input latch bits
        wr(ADDR_DATA, 8'h81);
        rd(ADDR_DATA);
        // Byte write issued while a bit set runs is dropped
        fork
            bit_set_instruction(3'h1);
            begin
                repeat (2) @(negedge clk);
                bus_addr = ADDR_DATA;
                bus_wdata = 8'hAA;
                bus_wr = 1'b1;
                @(negedge clk);
                bus_wr = 1'b0;
            end
        join
        check(pin_out, 8'h43);
        rd(ADDR_DATA);
        $display("Test bit set hazard done");
        for (int i = 0; i < 12; i++) begin
            ext = 8'($urandom);
            wr(ADDR_DIR, 8'($urandom));
            wr(ADDR_DATA, 8'($urandom));
            rd(ADDR_DATA);
            rd(ADDR_DIR);
            bit_set_instruction(3'($urandom_range(7, 0)));
            rd(ADDR_DATA);
        end
        $display("Test random traffic done");
        repeat (4) @(negedge clk);
        check(8'(exp_q.size()), 8'h00);
        stop_test();
    end
endmodule
